/* src/padc_pkg.sv */
package padc_pkg;
	localparam int unsigned sample_bits = 12;
	localparam int unsigned latency_cycles = 6;
	localparam logic [11:0] code_min = 12'h000;
	localparam logic [11:0] code_max = 12'hfff;
	localparam logic [11:0] code_reset = 12'h000;
	localparam logic [11:0] offset_zero = 12'h800;

	typedef struct packed {
		logic [11:0] data;
		logic oe;
	} padc_bus_type;

	typedef struct packed {
		logic [12:0] code;
		logic valid;
	} padc_stage_type;
endpackage

/* src/padc_port.sv */
module padc_port #(
	parameter int unsigned latency = padc_pkg::latency_cycles
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic signed [12:0] analog_level,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	output padc_pkg::padc_bus_type sample_word,
	output logic sample_valid
);
	logic [1:0] oe_sync_r;
	logic [1:0] sleep_sync_r;
	padc_pkg::padc_stage_type pipe_r [latency];
	logic [11:0] word_r;
	logic valid_r;
	logic [11:0] code_nxt;

	function automatic logic [11:0] padc_clip(input logic signed [12:0] lvl);
		logic signed [13:0] shifted;
		shifted = 14'(lvl) + $signed(14'(padc_pkg::offset_zero));
		if (shifted < 14'sh0000)
			padc_clip = padc_pkg::code_min;
		else if (shifted > $signed(14'(padc_pkg::code_max)))
			padc_clip = padc_pkg::code_max;
		else
			padc_clip = shifted[11:0];
	endfunction

	// Level inside the converter's span
	function automatic logic padc_in_range(input logic signed [12:0] lvl);
		padc_in_range = (lvl >= -13'sd2048) && (lvl <= 13'sd2047);
	endfunction

	// Pin synchronisers
	always_ff @(posedge clock) begin
		if (reset) begin
			oe_sync_r <= '1;
		end else begin
			oe_sync_r <= {oe_sync_r[0], output_enable_n};
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sleep_sync_r <= '1;
		end else begin
			sleep_sync_r <= {sleep_sync_r[0], sleep_request};
		end
	end

	// Converter core
	always_comb begin
		code_nxt = padc_clip(analog_level);
	end

	// Sampling stage
	always_ff @(posedge clock) begin
		if (reset) begin
			pipe_r[0] <= '0;
		end else begin
			pipe_r[0].code <= {1'b0, code_nxt};
			pipe_r[0].valid <= ~sleep_sync_r[1];
		end
	end

	// Remaining pipeline stages
	for (genvar g = 1; g < latency; g++) begin : g_stage
		always_ff @(posedge clock) begin
			if (reset) begin
				pipe_r[g] <= '0;
			end else begin
				pipe_r[g] <= pipe_r[g-1];
			end
		end
	end

	// Output word register
	always_ff @(posedge clock) begin
		if (reset) begin
			word_r <= padc_pkg::code_reset;
		end else if (pipe_r[latency-1].valid) begin
			word_r <= pipe_r[latency-1].code[11:0];
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= pipe_r[latency-1].valid;
		end
	end

	// Result assembly
	assign sample_word.data = word_r;
	assign sample_word.oe = ~oe_sync_r[1];
	assign sample_valid = valid_r;

	property p_latency;
		@(posedge clock) disable iff (reset)
		!sleep_sync_r[1] |-> ##7 (sample_valid && sample_word.data == $past(code_nxt, 7));
	endproperty
	a_latency: assert property (p_latency) else $error("Word latency wrong");

	property p_oe;
		@(posedge clock) disable iff (reset)
		!$past(reset) && !$past(reset, 2) |-> sample_word.oe == !$past(output_enable_n, 2);
	endproperty
	a_oe: assert property (p_oe) else $error("Output enable wrong");

	property p_sleep;
		@(posedge clock) disable iff (reset)
		sleep_sync_r[1] [*8] |-> !sample_valid;
	endproperty
	a_sleep: assert property (p_sleep) else $error("Converting while asleep");

	property p_hold;
		@(posedge clock) disable iff (reset)
		!sample_valid |-> $stable(sample_word.data);
	endproperty
	a_hold: assert property (p_hold) else $error("Word changed while idle");

	property p_low;
		@(posedge clock) disable iff (reset)
		(analog_level < -13'sd2048) |-> code_nxt == padc_pkg::code_min;
	endproperty
	a_low: assert property (p_low) else $error("Under range not zero");

	property p_high;
		@(posedge clock) disable iff (reset)
		(analog_level > 13'sd2047) |-> code_nxt == padc_pkg::code_max;
	endproperty
	a_high: assert property (p_high) else $error("Over range not saturated");

	property p_mid;
		@(posedge clock) disable iff (reset)
		(analog_level == 13'sd0) |-> code_nxt == padc_pkg::offset_zero;
	endproperty
	a_mid: assert property (p_mid) else $error("Offset binary wrong");

	property p_rate;
		@(posedge clock) disable iff (reset)
		(!sleep_sync_r[1]) [*8] |-> ##6 sample_valid [*2];
	endproperty
	a_rate: assert property (p_rate) else $error("Throughput below one per cycle");

	property p_reset_out;
		@(posedge clock)
		reset |=> (!sample_valid && !sample_word.oe && sample_word.data == padc_pkg::code_reset);
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("Outputs not quiet after reset");

	property p_valid_src;
		@(posedge clock) disable iff (reset)
		sample_valid |-> $past(!sleep_sync_r[1], 7);
	endproperty
	a_valid_src: assert property (p_valid_src) else $error("Word from a sleeping sample");

	property p_in_range;
		@(posedge clock) disable iff (reset)
		padc_in_range(analog_level) |-> code_nxt == 12'(analog_level + 13'sd2048);
	endproperty
	a_in_range: assert property (p_in_range) else $error("In range code wrong");

	property p_sleep_enter;
		@(posedge clock) disable iff (reset)
		$rose(sleep_sync_r[1]) |-> ##7 !sample_valid;
	endproperty
	a_sleep_enter: assert property (p_sleep_enter) else $error("Word after sleep began");

	property p_wake;
		@(posedge clock) disable iff (reset)
		$fell(sleep_sync_r[1]) |-> ##7 sample_valid;
	endproperty
	a_wake: assert property (p_wake) else $error("No word after wake");

	property p_oe_change;
		@(posedge clock) disable iff (reset)
		!$past(reset) && !$past(reset, 2) && !$past(reset, 3) && $changed(sample_word.oe)
			|-> $past(output_enable_n, 2) != $past(output_enable_n, 3);
	endproperty
	a_oe_change: assert property (p_oe_change) else $error("Output enable moved alone");

	property p_under_word;
		@(posedge clock) disable iff (reset)
		sample_valid && $past(analog_level, 7) < -13'sd2048 |-> sample_word.data == padc_pkg::code_min;
	endproperty
	a_under_word: assert property (p_under_word) else $error("Under range word not zero");

	property p_over_word;
		@(posedge clock) disable iff (reset)
		sample_valid && $past(analog_level, 7) > 13'sd2047 |-> sample_word.data == padc_pkg::code_max;
	endproperty
	a_over_word: assert property (p_over_word) else $error("Over range word not full");

	property p_mid_word;
		@(posedge clock) disable iff (reset)
		sample_valid && $past(analog_level, 7) == 13'sd0 |-> sample_word.data == padc_pkg::offset_zero;
	endproperty
	a_mid_word: assert property (p_mid_word) else $error("Mid scale word wrong");

	property p_sleep_sync;
		@(posedge clock) disable iff (reset)
		!$past(reset) && !$past(reset, 2) |-> sleep_sync_r[1] == $past(sleep_request, 2);
	endproperty
	a_sleep_sync: assert property (p_sleep_sync) else $error("Sleep sync depth wrong");
endmodule

/* verification/padc_capture.sv */
module padc_capture (
	input wire logic clock,
	input wire padc_pkg::padc_bus_type sample_word,
	input wire logic sample_valid,
	output logic [11:0] pin_level,
	output logic [11:0] captured_r
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] last_r = 12'h000;
	// Floating bus reads back as the inverse of its last level
	assign pin_level = sample_word.oe ? sample_word.data : ~last_r;
	always_ff @(posedge clock) begin
		if (sample_word.oe) last_r <= sample_word.data;
		if (sample_word.oe && sample_valid) captured_r <= pin_level;
	end
endmodule

/* verification/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, reset = 1, output_enable_n = 0, sleep_request = 0, sample_valid;
	logic signed [12:0] analog_level = 13'h0000;
	padc_pkg::padc_bus_type sample_word;
	logic [11:0] pin_level, captured_r;
	int bad_count = 0, comparisons = 0, cycles = 0;
	logic [12:0] lv [7] = '{13'h1448, 13'h1800, 13'h1fff, 13'h0000, 13'h0001, 13'h07ff, 13'h0bb8};
	logic [11:0] cd [7] = '{12'h000, 12'h000, 12'h7ff, 12'h800, 12'h801, 12'hfff, 12'hfff};
	always #5 clock = ~clock;
	always @(posedge clock) if (++cycles == 400) begin
		bad_count++;
		give_verdict();
	end
	padc_port u_padc_port (.clock(clock), .reset(reset), .analog_level(analog_level),
		.output_enable_n(output_enable_n), .sleep_request(sleep_request),
		.sample_word(sample_word), .sample_valid(sample_valid));
	padc_capture u_padc_capture (.clock(clock), .sample_word(sample_word),
		.sample_valid(sample_valid), .pin_level(pin_level), .captured_r(captured_r));
	task chk(string name, logic [11:0] e, logic [11:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask
	task give_verdict();
		$display("Comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task wt(int n);
		repeat (n) @(negedge clock);
	endtask
	initial begin
		wt(2);
		reset = 0;
		chk("valid", 12'h000, {11'h000, sample_valid});
		for (int i = 0; i < 7; i++) begin
			analog_level = lv[i];
			wt(9);
			chk("data", cd[i], sample_word.data);
			chk("valid", 12'h001, {11'h000, sample_valid});
			chk("captured", cd[i], captured_r);
		end
		// Edge-exact latency
		analog_level = 13'h0005;
		wt(6);
		chk("data", 12'hfff, sample_word.data);
		wt(1);
		chk("data", 12'h805, sample_word.data);
		// Power down holds last word
		sleep_request = 1;
		wt(4);
		analog_level = 13'h0000;
		wt(9);
		chk("valid", 12'h000, {11'h000, sample_valid});
		chk("data", 12'h805, sample_word.data);
		sleep_request = 0;
		wt(12);
		chk("data", 12'h800, sample_word.data);
		output_enable_n = 1;
		wt(3);
		chk("oe", 12'h000, {11'h000, sample_word.oe});
		chk("pin", 12'h7ff, pin_level);
		output_enable_n = 0;
		wt(3);
		chk("oe", 12'h001, {11'h000, sample_word.oe});
		// Mid-run reset
		reset = 1;
		wt(2);
		chk("valid", 12'h000, {11'h000, sample_valid});
		chk("data", 12'h000, sample_word.data);
		chk("oe", 12'h000, {11'h000, sample_word.oe});
		reset = 0;
		wt(1);
		chk("oe", 12'h000, {11'h000, sample_word.oe});
		wt(9);
		chk("data", 12'h800, sample_word.data);
		give_verdict();
	end
endmodule
